// >>> shared/scm_pkg.sv
// constants, map layout and state types for the start-up configuration map loader
package scm_pkg;
  // core clock and the initialisation delay after reset
  localparam int SCM_CORE_CLK_HZ  = 25_000_000;
  localparam int SCM_INIT_TIME_MS = 10;
  localparam int SCM_INIT_CYCLES  = SCM_INIT_TIME_MS * (SCM_CORE_CLK_HZ / 1000);
  localparam int SCM_INIT_W       = 18;
  // link clock and serial clock, one quarter of a serial bit per divider run
  localparam int SCM_LINK_CLK_NS  = 48;
  localparam int SCM_SCL_HZ       = 100_000;
  localparam int SCM_QTR_DEN      = 4 * SCM_SCL_HZ * SCM_LINK_CLK_NS;
  localparam int SCM_LINK_DIV     = (1_000_000_000 + SCM_QTR_DEN - 1) / SCM_QTR_DEN;
  localparam int SCM_DIV_W        = 8;
  // map length read from the memory: bytes 00H up to 19H
  localparam int SCM_MAP_LEN      = 26;
  // two-wire bus addressing of the configuration memory
  localparam logic [7:0] SCM_DEV_ADDR_WR = 8'hA0;
  localparam logic [7:0] SCM_DEV_ADDR_RD = 8'hA1;
  localparam logic [7:0] SCM_MAP_START   = 8'h00;
  // recognition pattern
  localparam logic [7:0] SCM_SIG_LOW     = 8'hAA;
  localparam logic [7:0] SCM_SIG_HIGH    = 8'h55;
  // map byte offsets
  localparam logic [5:0] SCM_OFS_SIG_LOW   = 6'h00;
  localparam logic [5:0] SCM_OFS_SIG_HIGH  = 6'h01;
  localparam logic [5:0] SCM_OFS_RATE_CTRL = 6'h02;
  localparam logic [5:0] SCM_OFS_MODE_ZERO = 6'h03;
  localparam logic [5:0] SCM_OFS_MODE_ONE  = 6'h04;
  localparam logic [5:0] SCM_OFS_IO_SEL    = 6'h05;
  localparam logic [5:0] SCM_OFS_BOOST     = 6'h19;
  // sequencer steps on the link: 0 start, 1 addr wr, 2 offset, 3 restart, 4 addr rd, 5.. reads
  localparam logic [5:0] SCM_STEP_RESTART = 6'h03;
  localparam logic [5:0] SCM_STEP_READ    = 6'h05;
  localparam logic [5:0] SCM_STEP_END     = 6'h1F;
  // tone feature modes and bass gain ceilings in 0.1 dB
  localparam logic [1:0] SCM_TONE_FLAT    = 2'h0;
  localparam logic [1:0] SCM_TONE_MAX     = 2'h3;
  localparam logic [9:0] SCM_BASS_MIN_CAP = 10'h089;
  localparam logic [9:0] SCM_BASS_MAX_CAP = 10'h0E8;
  localparam logic [7:0] SCM_CLIP_LIMIT   = 8'hF0;
  // built-in maps, each {byte19, byte5, byte4, byte3, byte2}
  localparam logic [39:0] SCM_BUILTIN [4] = '{40'h01_00_80_00_0B, 40'h01_80_80_20_0B,
                                             40'h01_80_80_60_0B, 40'h00_00_80_10_07};
  // link sequencer states
  typedef enum logic [3:0] {LK_IDLE = 4'h1, LK_START = 4'h2, LK_XFER = 4'h4, LK_STOP = 4'h8} scm_lst_t;
  // loader states
  typedef enum logic [4:0] {LD_INIT = 5'h01, LD_FETCH = 5'h02, LD_WAIT = 5'h04,
                            LD_PINS = 5'h08, LD_DONE = 5'h10} scm_cst_t;
endpackage

// >>> logic/scm_loader.sv
// start-up configuration map loader: two-wire memory reader on the link clock and map decode
// Function
// - bass gain capped 13.7/23.2 dB, flat zero
// - bass boost follows host request
// - boost not advertised when byte 19H zero
// - clipping prevention reduces bass gain
// - de-emphasis from mode byte bit 4
// - wait 10 ms after reset before loading
// - act as bus master, read memory
// - memory present only if AAH then 55H
// - memory map replaces built-in map
// - no memory: two pins pick built-in map
// - chosen configuration stays fixed afterwards
// - sample width from byte 2 bits 3:2
// - stereo bit 1, mono inversion bit 4
// - rate converter runs when byte 2 bit0
// - mode byte zero selector, tone mode bits
// - converter reset, channel swap, sync mode
// - start-up mute from byte 3 bit 1
// - output format bits 6:5, robust clock bit 7
// - mode byte one selector, lock speed bits
`timescale 1ns/1ps

// link side: bit engine that reads the map over the two-wire bus
module scm_link
  import scm_pkg::*;
(
  input  wire logic       link_clk,     // link clock
  input  wire logic       srst,         // core reset, synchronised here
  input  wire logic       go_tgl,       // toggles once per load request
  input  wire logic       sda_in,       // data line level
  output logic            scl_out,      // clock line drive value
  output logic            scl_oe,       // clock line pulled low
  output logic            sda_out,      // data line drive value
  output logic            sda_oe,       // data line pulled low
  output logic [7:0]      rx_byte,      // last byte received
  output logic [5:0]      rx_idx,       // its map offset
  output logic            byte_tgl,     // toggles per received byte
  output logic            done_tgl,     // toggles when a transfer ends
  output logic            nack          // memory failed to acknowledge
);
  typedef struct packed {
    logic [1:0]           rst_sync;     // reset synchroniser
    logic [2:0]           go_sync;      // request synchroniser and history
    logic [1:0]           sda_sync;     // data line synchroniser
    scm_lst_t             st;           // sequencer state
    logic [1:0]           ph;           // quarter of a serial bit
    logic [SCM_DIV_W-1:0] div;          // quarter-bit divider
    logic [3:0]           bitn;         // bit within byte, 8 is the ack slot
    logic [5:0]           step;         // transfer step
    logic [7:0]           sh;           // shift register
    logic                 rbit;         // sampled data bit
    logic                 nack;         // no acknowledge seen
    logic [7:0]           rx_byte;      // received byte
    logic [5:0]           rx_idx;       // offset of received byte
    logic                 byte_tgl;     // byte event toggle
    logic                 done_tgl;     // end event toggle
    logic                 scl_oe;       // clock line enable
    logic                 sda_oe;       // data line enable
  } scm_link_s_t;

  scm_link_s_t s;                       // state
  scm_link_s_t next_s;                  // next state

  // byte to send at a write step
  function automatic logic [7:0] tx_byte(input logic [5:0] step);
    logic [7:0] b;
    b = SCM_DEV_ADDR_RD;
    if (step == 6'h01) b = SCM_DEV_ADDR_WR;
    if (step == 6'h02) b = SCM_MAP_START;
    return b;
  endfunction

  // sequencer: start, address write, offset 0, restart, address read, sequential reads, stop
  always_comb begin
    logic                 tick;
    logic                 writing;
    logic                 last;
    logic [5:0]           nstep;
    next_s          = s;
    tick            = (s.div == SCM_DIV_W'(SCM_LINK_DIV - 1));
    writing         = (s.step < SCM_STEP_READ);
    last            = (s.step == SCM_STEP_READ + 6'(SCM_MAP_LEN - 1));
    nstep           = s.step + 6'h01;
    next_s.go_sync  = {s.go_sync[1:0], go_tgl};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.div      = (tick || s.st == LK_IDLE) ? '0 : s.div + SCM_DIV_W'(1);
    if (tick) begin
      next_s.ph = s.ph + 2'h1;
    end
    // line drive, registered one cycle behind the phase
    next_s.scl_oe = 1'b0;
    next_s.sda_oe = 1'b0;
    unique case (s.st)
      LK_IDLE: begin
        // start on a request toggle seen past the synchroniser
        if (s.go_sync[2] ^ s.go_sync[1]) begin
          next_s.st   = LK_START;
          next_s.step = '0;
          next_s.ph   = '0;
          next_s.nack = 1'b0;
        end
      end
      LK_START: begin
        // clock low, data high, clock high, data falls, clock low
        next_s.scl_oe = (s.ph == 2'h0) || (s.ph == 2'h3);
        next_s.sda_oe = s.ph[1];
        if (tick && s.ph == 2'h3) begin
          next_s.st   = LK_XFER;
          next_s.bitn = '0;
          next_s.step = nstep;
          next_s.sh   = tx_byte(nstep);
        end
      end
      LK_XFER: begin
        // clock low for two quarters, high for two; data changes only while low
        next_s.scl_oe = !s.ph[1];
        if (s.bitn[3]) begin
          next_s.sda_oe = !writing && !last;
        end else begin
          next_s.sda_oe = writing && !s.sh[7];
        end
        if (tick && s.ph == 2'h2) begin
          next_s.rbit = s.sda_sync[1];
        end
        if (tick && s.ph == 2'h3) begin
          if (!s.bitn[3]) begin
            next_s.sh   = {s.sh[6:0], s.rbit};
            next_s.bitn = s.bitn + 4'h1;
          end else begin
            next_s.bitn = '0;
            next_s.step = nstep;
            if (!writing) begin
              // hand the byte to the core domain
              next_s.rx_byte  = s.sh;
              next_s.rx_idx   = s.step - SCM_STEP_READ;
              next_s.byte_tgl = !s.byte_tgl;
            end
            if (writing && s.rbit) begin
              next_s.nack = 1'b1;
              next_s.st   = LK_STOP;
            end else if (nstep == SCM_STEP_RESTART) begin
              next_s.st = LK_START;
            end else if (last) begin
              next_s.st = LK_STOP;
            end else begin
              next_s.sh = tx_byte(nstep);
            end
          end
        end
      end
      LK_STOP: begin
        // clock low, data falls while low, clock high, data rises while high
        next_s.scl_oe = !s.ph[1];
        next_s.sda_oe = (s.ph != 2'h3);
        if (tick && s.ph == 2'h3) begin
          next_s.st       = LK_IDLE;
          next_s.done_tgl = !s.done_tgl;
        end
      end
      default: begin
        next_s.st = LK_IDLE;
      end
    endcase
    // data holds through quarter 0 so it never moves on the clock's falling edge
    if (s.st != LK_IDLE && s.ph == 2'h0) next_s.sda_oe = s.sda_oe;
    next_s.rst_sync = {s.rst_sync[0], srst};
    // link reset follows the core reset through the synchroniser
    if (s.rst_sync[1]) begin
      next_s          = '0;
      next_s.st       = LK_IDLE;
      next_s.rst_sync = {s.rst_sync[0], srst};
      next_s.go_sync  = {go_tgl, go_tgl, go_tgl};
    end
  end

  // state register on the link clock
  always_ff @(posedge link_clk) begin
    s <= next_s;
  end

  assign scl_out  = 1'b0;
  assign sda_out  = 1'b0;
  assign scl_oe   = s.scl_oe;
  assign sda_oe   = s.sda_oe;
  assign rx_byte  = s.rx_byte;
  assign rx_idx   = s.rx_idx;
  assign byte_tgl = s.byte_tgl;
  assign done_tgl = s.done_tgl;
  assign nack     = s.nack;
endmodule // scm_link

// core side: start-up sequence, map choice and decoded configuration
module scm_loader
  import scm_pkg::*;
#(
  parameter int INIT_CYCLES = SCM_INIT_CYCLES // start-up delay in core cycles
) (
  input  wire logic       core_clk,           // core clock, 25 MHz
  input  wire logic       srst,               // synchronous reset, active high
  input  wire logic       link_clk,           // link clock
  input  wire logic       scl_in,             // clock line level, unused without stretching
  output logic            scl_out,            // clock line drive value
  output logic            scl_oe,             // clock line pulled low
  input  wire logic       sda_in,             // data line level
  output logic            sda_out,            // data line drive value
  output logic            sda_oe,             // data line pulled low
  input  wire logic       map_select_pin_a,   // built-in map select, low bit
  input  wire logic       map_select_pin_b,   // built-in map select, high bit
  input  wire logic [7:0] bass_level_request, // host bass level, 0.2 dB steps in minimum tone mode, 0.25 dB in maximum
  input  wire logic [7:0] volume_gain,        // volume gain, 0.1 dB units
  input  wire logic       bass_boost_request, // host bass boost switch
  output logic            config_done,        // map loaded and fixed
  output logic            eeprom_found,       // map came from the memory
  output logic [7:0]      rate_converter_control, // map byte 2
  output logic [7:0]      converter_mode_zero,    // map byte 3
  output logic [1:0]      sample_width,       // 01 8, 10 16, 11 24 bit
  output logic            stereo,             // stereo when high
  output logic            mono_invert,        // mono phase inversion
  output logic            rate_conv_run,      // sample rate converter running
  output logic [1:0]      out_format,         // serial output format
  output logic            robust_wclk,        // robust word clock
  output logic [1:0]      tone_mode,          // flat, minimum or maximum
  output logic            deemph_on,          // 44.1 kHz de-emphasis
  output logic            chan_swap,          // left and right swapped
  output logic            sync_mode,          // synchronous operation
  output logic            conv_reset,         // converter core held in reset
  output logic            mute,               // output muted
  output logic [1:0]      pll_lock_speed,     // lock speed selection
  output logic            map_layout_ok,      // mode byte selectors as expected
  output logic            clip_prevent,       // clipping prevention enabled
  output logic            boost_advertised,   // bass boost offered to the host
  output logic            low_frequency_boost,// bass boost active
  output logic [7:0]      bass_gain           // applied bass gain, 0.1 dB units
);
  typedef struct packed {
    scm_cst_t             st;           // loader state
    logic [SCM_INIT_W-1:0] timer;       // start-up delay counter
    logic                 go_tgl;       // load request toggle
    logic [2:0]           byte_sync;    // byte toggle synchroniser and history
    logic [2:0]           done_sync;    // end toggle synchroniser and history
    logic [1:0]           sel_a;        // select pin a synchroniser
    logic [1:0]           sel_b;        // select pin b synchroniser
    logic                 found;        // map from memory
    logic                 done;         // map fixed
    logic [7:0]           sig_low;      // map byte 0
    logic [7:0]           sig_high;     // map byte 1
    logic [7:0]           rate_ctrl;    // map byte 2
    logic [7:0]           mode_zero;    // map byte 3
    logic [7:0]           mode_one;     // map byte 4
    logic [7:0]           io_sel;       // map byte 5
    logic [7:0]           boost;        // map byte 19H
    logic                 mute;         // gated mute
    logic                 conv_reset;   // gated converter reset
    logic                 run;          // gated converter run
    logic                 boost_on;     // bass boost switch
    logic [7:0]           gain;         // applied bass gain
  } scm_core_s_t;

  scm_core_s_t s;                       // state
  scm_core_s_t next_s;                  // next state
  logic [7:0]  lk_byte;                 // byte from the link, stable between toggles
  logic [5:0]  lk_idx;                  // its offset
  logic        lk_byte_tgl;             // byte toggle from the link
  logic        lk_done_tgl;             // end toggle from the link
  logic        lk_nack;                 // no-ack level, stable after the end toggle

  scm_link u_link (
    .link_clk (link_clk),
    .srst     (srst),
    .go_tgl   (s.go_tgl),
    .sda_in   (sda_in),
    .scl_out  (scl_out),
    .scl_oe   (scl_oe),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .rx_byte  (lk_byte),
    .rx_idx   (lk_idx),
    .byte_tgl (lk_byte_tgl),
    .done_tgl (lk_done_tgl),
    .nack     (lk_nack)
  );

  // loader sequence, map capture and gated controls
  always_comb begin
    logic [39:0] map;
    logic [1:0]  sel;
    logic [9:0]  raw;
    logic [9:0]  sum;
    raw              = '0;
    sum              = '0;
    next_s           = s;
    next_s.byte_sync = {s.byte_sync[1:0], lk_byte_tgl};
    next_s.done_sync = {s.done_sync[1:0], lk_done_tgl};
    next_s.sel_a     = {s.sel_a[0], map_select_pin_a};
    next_s.sel_b     = {s.sel_b[0], map_select_pin_b};
    sel              = {s.sel_b[1], s.sel_a[1]};
    map              = SCM_BUILTIN[sel];
    unique case (s.st)
      LD_INIT: begin
        // settle internal settings before touching the bus
        next_s.timer = s.timer + SCM_INIT_W'(1);
        if (s.timer == SCM_INIT_W'(INIT_CYCLES - 1)) begin
          next_s.st = LD_FETCH;
        end
      end
      LD_FETCH: begin
        next_s.go_tgl = !s.go_tgl;
        next_s.st     = LD_WAIT;
      end
      LD_WAIT: begin
        // keep bytes 00H to 05H and 19H by offset as they arrive, others dropped
        if (s.byte_sync[2] ^ s.byte_sync[1]) begin
          unique case (lk_idx)
            SCM_OFS_SIG_LOW:   next_s.sig_low   = lk_byte;
            SCM_OFS_SIG_HIGH:  next_s.sig_high  = lk_byte;
            SCM_OFS_RATE_CTRL: next_s.rate_ctrl = lk_byte;
            SCM_OFS_MODE_ZERO: next_s.mode_zero = lk_byte;
            SCM_OFS_MODE_ONE:  next_s.mode_one  = lk_byte;
            SCM_OFS_IO_SEL:    next_s.io_sel    = lk_byte;
            SCM_OFS_BOOST:     next_s.boost     = lk_byte;
            default: begin
            end
          endcase
        end
        if (s.done_sync[2] ^ s.done_sync[1]) begin
          // only a full pattern and a clean read count as a memory
          if (!lk_nack && s.sig_low == SCM_SIG_LOW && s.sig_high == SCM_SIG_HIGH) begin
            next_s.found = 1'b1;
            next_s.done  = 1'b1;
            next_s.st    = LD_DONE;
          end else begin
            next_s.st = LD_PINS;
          end
        end
      end
      LD_PINS: begin
        // built-in map chosen by the two select pins
        next_s.rate_ctrl = map[7:0];
        next_s.mode_zero = map[15:8];
        next_s.mode_one  = map[23:16];
        next_s.io_sel    = map[31:24];
        next_s.boost     = map[39:32];
        next_s.done      = 1'b1;
        next_s.st        = LD_DONE;
      end
      LD_DONE: begin
        // map bytes are never written again
        next_s.st = LD_DONE;
      end
      default: begin
        next_s.st = LD_INIT;
      end
    endcase
    // start-up controls held safe until the map is fixed
    next_s.mute       = !s.done || s.mode_zero[1];
    next_s.conv_reset = !s.done || s.mode_zero[0];
    next_s.run        = s.done && s.rate_ctrl[0];
    next_s.boost_on   = s.done && bass_boost_request;
    // bass gain: about 2 and 2.5 tenths per request step, capped per mode
    if (s.mode_zero[6:5] == SCM_TONE_FLAT) begin
      raw = '0;
    end else if (s.mode_zero[6:5] == SCM_TONE_MAX) begin
      raw = 10'(({3'h0, bass_level_request} * 11'h005) >> 1);
      if (raw > SCM_BASS_MAX_CAP) raw = SCM_BASS_MAX_CAP;
    end else begin
      raw = {1'b0, bass_level_request, 1'b0};
      if (raw > SCM_BASS_MIN_CAP) raw = SCM_BASS_MIN_CAP;
    end
    // with clipping prevention on, cut bass to the clip point minus volume, or to zero once volume reaches the clip point
    sum = raw + {2'h0, volume_gain};
    if (s.io_sel[7] && sum > {2'h0, SCM_CLIP_LIMIT}) begin
      if (volume_gain >= SCM_CLIP_LIMIT) begin
        raw = '0;
      end else begin
        raw = {2'h0, SCM_CLIP_LIMIT - volume_gain};
      end
    end
    next_s.gain = s.done ? raw[7:0] : 8'h00;
  end

  // state register on the core clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s    <= '0;
      s.st <= LD_INIT;
      s.mute       <= 1'b1;                 // muted and converter held while in reset
      s.conv_reset <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // decoded fields from map byte flops; status, gated controls and bass gain from their own flops
  assign config_done            = s.done;
  assign eeprom_found           = s.found;
  assign rate_converter_control = s.rate_ctrl;
  assign converter_mode_zero    = s.mode_zero;
  assign sample_width           = s.rate_ctrl[3:2];
  assign stereo                 = s.rate_ctrl[1];
  assign mono_invert            = s.rate_ctrl[4];
  assign rate_conv_run          = s.run;
  assign out_format             = s.rate_ctrl[6:5];
  assign robust_wclk            = s.rate_ctrl[7];
  assign tone_mode              = s.mode_zero[6:5];
  assign deemph_on              = s.mode_zero[4];
  assign chan_swap              = s.mode_zero[3];
  assign sync_mode              = s.mode_zero[2];
  assign conv_reset             = s.conv_reset;
  assign mute                   = s.mute;
  assign pll_lock_speed         = s.mode_one[6:5];
  assign map_layout_ok          = !s.mode_zero[7] && s.mode_one[7];
  assign clip_prevent           = s.io_sel[7];
  assign boost_advertised       = s.done && (s.boost != 8'h00);
  assign low_frequency_boost    = s.boost_on;
  assign bass_gain              = s.gain;
endmodule // scm_loader

// >>> verification/scm_eeprom_model.sv
// behavioural two-wire configuration memory with sequential reads
`timescale 1ns/1ps
module scm_eeprom_model (
  input  wire logic scl,     // clock line level
  input  wire logic sda,     // data line level
  input  wire logic present, // low: nothing acknowledges
  output logic      pull     // high pulls data low
);
  logic [7:0] mem [32] = '{0: 8'hAA, 1: 8'h55, 2: 8'hAD, 3: 8'h7A, 4: 8'hC0, 5: 8'h80, default: 8'h00};
  logic [7:0] sh  = 8'h00;  // shifted bits
  logic       rd  = 1'b0;   // read phase
  logic       drv = 1'b0;   // data pull
  int         bc = 0, nb = 0, ptr = 0;
  assign pull = drv;
  // start or repeated start restarts framing
  always @(negedge sda) if (scl) begin
    bc = 0;
    nb = 0;
  end
  // sample on clock high, a master nack ends the read
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    bc = (bc == 9) ? 1 : bc + 1;
    if (bc == 9 && sda) rd = 1'b0;
  end
  // change the drive only on the clock's falling edge
  always @(negedge scl) begin
    drv = 1'b0;
    if (bc == 8) begin
      if (nb == 0) rd = sh[0];
      if (nb == 1 && !rd) ptr = sh;
      if (nb == 0 || !rd) drv = present;
      else ptr++;
      nb++;
    end else if (rd && nb > 0) drv = !mem[ptr][bc == 9 ? 7 : 7 - bc];
  end
endmodule // scm_eeprom_model

// >>> verification/scm_loader_assertions.sv
// checker for the loader's configuration outputs
`timescale 1ns/1ps
module scm_loader_assertions
  import scm_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       srst,
  input wire logic       config_done,
  input wire logic       eeprom_found,
  input wire logic [7:0] rate_converter_control,
  input wire logic [7:0] converter_mode_zero,
  input wire logic [1:0] sample_width,
  input wire logic       stereo,
  input wire logic       rate_conv_run,
  input wire logic [1:0] tone_mode,
  input wire logic       deemph_on,
  input wire logic       conv_reset,
  input wire logic       mute,
  input wire logic       boost_advertised,
  input wire logic       low_frequency_boost,
  input wire logic       bass_boost_request,
  input wire logic [7:0] bass_gain
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_mute_early: assert property (!config_done |-> mute && conv_reset) else $error("not muted");
  a_idle_early: assert property (!config_done |-> !rate_conv_run && !boost_advertised && bass_gain == 8'h00)
    else $error("active before load");
  a_map_fixed: assert property (config_done |=> config_done && $stable(converter_mode_zero)) else $error("map moved");
  a_width_bits: assert property (config_done |=> sample_width == rate_converter_control[3:2]
    && stereo == rate_converter_control[1]) else $error("width or stereo");
  a_run_follow: assert property (config_done |=> rate_conv_run == rate_converter_control[0]) else $error("run");
  a_mode_bits: assert property (config_done |=> tone_mode == converter_mode_zero[6:5]
    && deemph_on == converter_mode_zero[4]) else $error("tone or deemphasis");
  a_mute_follow: assert property (config_done |=> mute == converter_mode_zero[1]
    && conv_reset == converter_mode_zero[0]) else $error("mute or reset");
  a_boost_follow: assert property (config_done |=> low_frequency_boost == $past(bass_boost_request))
    else $error("boost");
  a_bass_cap: assert property (config_done |=> bass_gain <= (tone_mode == 2'h3 ? 8'hE8
    : tone_mode == 2'h0 ? 8'h00 : 8'h89)) else $error("bass cap");
  c_found: cover property (config_done && eeprom_found);
  c_pins: cover property (config_done && !eeprom_found);
  c_boost: cover property (low_frequency_boost);
endmodule // scm_loader_assertions
bind scm_loader scm_loader_assertions i_chk (.*);

// >>> verification/tb_scm_loader.sv
// self-checking bench for the start-up configuration map loader
`timescale 1ns/1ps
module tb_scm_loader;
  import scm_pkg::*;
  logic       core_clk = 0, link_clk = 0, srst = 1;
  logic       pin_a = 0, pin_b = 0, boost = 0, present = 0;
  logic [7:0] bass = 8'h00, vol = 8'h00;
  logic       scl_oe, sda_oe, pull, done, found, lfb, adv;
  logic [7:0] rcc, cmz, gain;
  logic [1:0] pll, fmt;
  logic       ok, clip, swap, sync, rob, inv;
  wire        scl = ~scl_oe;          // pulled-up lines
  wire        sda = ~(sda_oe | pull);
  int         num_errors = 0, total_checks = 0;
  scm_loader #(.INIT_CYCLES(50)) i_dut (.core_clk(core_clk), .srst(srst), .link_clk(link_clk),
    .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .map_select_pin_a(pin_a), .map_select_pin_b(pin_b), .bass_level_request(bass), .volume_gain(vol),
    .bass_boost_request(boost), .config_done(done), .eeprom_found(found), .rate_converter_control(rcc),
    .converter_mode_zero(cmz), .sample_width(), .stereo(), .mono_invert(inv), .rate_conv_run(),
    .out_format(fmt), .robust_wclk(rob), .tone_mode(), .deemph_on(), .chan_swap(swap), .sync_mode(sync),
    .conv_reset(), .mute(), .pll_lock_speed(pll), .map_layout_ok(ok), .clip_prevent(clip),
    .boost_advertised(adv), .low_frequency_boost(lfb), .bass_gain(gain));
  scm_eeprom_model i_mem (.scl(scl), .sda(sda), .present(present), .pull(pull));
  initial begin forever #20 core_clk = ~core_clk; end
  initial begin #7; forever #24 link_clk = ~link_clk; end
  // step just past n core edges
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // compare one byte-wide result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reset five cycles, then wait boundedly for the fixed map
  task automatic load;
    int n;
    srst = 1;
    tick(5);
    srst = 0;
    n = 0;
    while (done !== 1'b1 && n < 90000) begin
      tick(1);
      n++;
    end
    if (n == 90000) begin
      num_errors++;
      final_report();
    end
    tick(2);
  endtask
  // no memory: each pin code picks its built-in map
  task automatic t_pins;
    logic [7:0] b2 [4] = '{8'h0B, 8'h0B, 8'h0B, 8'h07};
    logic [7:0] b3 [4] = '{8'h00, 8'h20, 8'h60, 8'h10};
    present = 0;
    for (int i = 0; i < 4; i++) begin
      {pin_b, pin_a} = 2'(i);
      load();
      chk(rcc, b2[i]);
      chk(cmz, b3[i]);
      chk({7'h00, found}, 8'h00);
      chk({7'h00, adv}, {7'h00, i != 3});
      chk({7'h00, ok}, 8'h01);
    end
  endtask
  // memory fitted: its map wins over the pins
  task automatic t_mem;
    present = 1;
    {pin_b, pin_a} = 2'h3;
    load();
    chk({7'h00, found}, 8'h01);
    chk(rcc, 8'hAD);
    chk(cmz, 8'h7A);
    chk({7'h00, adv}, 8'h00);
    chk({ok, clip, swap, sync, rob, inv, fmt}, 8'hE9);
    chk({6'h00, pll}, 8'h02);
  endtask
  // maximum tone mode: scaling, cap, clip and boost switch
  task automatic t_bass;
    bass = 8'h15;
    tick(2);
    chk(gain, 8'h34);
    bass = 8'h7F;
    tick(2);
    chk(gain, 8'hE8);
    vol = 8'h64;
    tick(2);
    chk(gain, 8'h8C);
    boost = 1;
    tick(2);
    chk({7'h00, lfb}, 8'h01);
  endtask
  initial begin
    t_pins();
    t_mem();
    t_bass();
    final_report();
  end
endmodule // tb_scm_loader
